// ==== verilog/nvc_pkg.sv ====
package nvc_pkg;

	// register word offsets on the apb bus (byte addresses)
	localparam logic [7:0] NVC_OFF_ADDR_LOW  = 8'h00;
	localparam logic [7:0] NVC_OFF_ADDR_HIGH = 8'h04;
	localparam logic [7:0] NVC_OFF_DATA      = 8'h08;
	localparam logic [7:0] NVC_OFF_KEY       = 8'h0c;
	localparam logic [7:0] NVC_OFF_CTRL      = 8'h10;
	localparam logic [7:0] NVC_OFF_FLAGS4    = 8'h14;
	localparam logic [7:0] NVC_OFF_ENABLES4  = 8'h18;
	localparam logic [7:0] NVC_OFF_PRIO4     = 8'h1c;

	// control/status field positions
	localparam int NVC_BIT_READ    = 0;
	localparam int NVC_BIT_COMMIT  = 1;
	localparam int NVC_BIT_PERMIT  = 2;
	localparam int NVC_BIT_ABORT   = 3;
	localparam int NVC_BIT_ERASE   = 4;
	localparam int NVC_BIT_CFGSEL  = 6;
	localparam int NVC_BIT_PGMSEL  = 7;
	// done flag position in group-4 flag/enable/priority registers
	localparam int NVC_BIT_DONE    = 6;

	// unlock key values
	localparam logic [7:0] NVC_KEY_FIRST  = 8'h55;
	localparam logic [7:0] NVC_KEY_SECOND = 8'haa;

	// writable masks; bit 5 of control and bit 3 of group-4 are unimplemented
	localparam logic [7:0] NVC_CTRL_WMASK = 8'hd4;
	localparam logic [7:0] NVC_G4_MASK    = 8'hf7;
	localparam logic [7:0] NVC_ZERO_BYTE  = 8'h00;

	// array geometry
	localparam int NVC_ADDR_W  = 10;
	localparam int NVC_DEPTH   = 1024;

	// timing at 40 MHz
	localparam int NVC_CLK_MHZ        = 40;
	localparam int NVC_PROG_TIME_US   = 4000;
	localparam int NVC_PWRT_TIME_US   = 65000;
	localparam int NVC_PROG_CYCLES    = NVC_PROG_TIME_US * NVC_CLK_MHZ;
	localparam int NVC_PWRT_CYCLES    = NVC_PWRT_TIME_US * NVC_CLK_MHZ;

	typedef enum logic [1:0]
	{
		NVC_KEY_IDLE = 2'b00,
		NVC_KEY_HALF = 2'b01,
		NVC_KEY_OPEN = 2'b10
	} nvc_key_t;

endpackage

// ==== verilog/nvc_prog_timer.sv ====
`timescale 1ns/1ps
// one-shot down counter: busy from start pulse for LEN cycles
module nvc_prog_timer
#(
	parameter int LEN = 16
)
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic start_i,
	input  wire logic abort_i,
	output logic      busy_o,
	output logic      done_o
);
	localparam int CW = $clog2(LEN + 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          done_q;
	logic          done_d;

	always_comb
	begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (abort_i)
		begin
			cnt_d = '0;
		end
		else if (start_i)
		begin
			cnt_d = CW'(LEN);
		end
		else if (cnt_q != '0)
		begin
			cnt_d = cnt_q - CW'(1);
			done_d = (cnt_q == CW'(1));
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy_o = (cnt_q != '0);
	assign done_o = done_q;
endmodule

// ==== verilog/nvc_top.sv ====
`timescale 1ns/1ps
module nvc_top
	import nvc_pkg::*;
#(
	parameter int PROG_CYCLES = NVC_PROG_CYCLES,
	parameter int PWRT_CYCLES = NVC_PWRT_CYCLES
)
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_B_I,
	input  wire logic        POR_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        CODE_PROTECT_I,
	input  wire logic        EXT_REQ_I,
	input  wire logic        EXT_WRITE_I,
	input  wire logic [9:0]  EXT_ADDR_I,
	input  wire logic [7:0]  EXT_WDATA_I,
	output logic      [7:0]  EXT_RDATA_O,
	output logic             EXT_DENIED_O,
	input  wire logic        LOW_POWER_OSC_I,
	output logic             HIGH_POWER_REQ_O,
	output logic             DONE_IRQ_O
);

	////////////////////////////////////////////////////////////////////
	// bus decode
	logic       wr_acc;
	logic       rd_acc;
	logic [7:0] wbyte;
	assign wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
	assign rd_acc   = PSEL_I && PENABLE_I && !PWRITE_I;
	assign wbyte    = PWDATA_I[7:0];
	assign PREADY_O = 1'b1;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= NVC_OFF_PRIO4) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic hit(input logic acc, input logic [7:0] a, input logic [7:0] off);
		hit = acc && (a == off);
	endfunction

	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped(PADDR_I);

	////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]            adr_lo_q, adr_lo_d;
	logic [7:0]            adr_hi_q, adr_hi_d;
	logic [7:0]            data_q, data_d;
	logic [7:0]            ctrl_q, ctrl_d;
	logic [7:0]            flags4_q, flags4_d;
	logic [7:0]            en4_q, en4_d;
	logic [7:0]            prio4_q, prio4_d;
	nvc_key_t              key_q, key_d;
	logic [NVC_ADDR_W-1:0] wadr_q, wadr_d;
	logic [7:0]            wdat_q, wdat_d;
	logic [7:0]            ext_q, ext_d;
	logic                  ext_den_q, ext_den_d;
	logic                  pwrt_busy;
	logic                  prog_busy;
	logic                  prog_done;
	logic                  launch;
	logic                  rst_seen_q;
	logic [7:0]            mem [NVC_DEPTH];

	logic [NVC_ADDR_W-1:0] cur_adr;
	assign cur_adr = {adr_hi_q[1:0], adr_lo_q};

	logic write_busy;
	assign write_busy = ctrl_q[NVC_BIT_COMMIT];

	////////////////////////////////////////////////////////////////////
	// power-up timer, reuses the one-shot counter
	logic por_start_q;
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			por_start_q <= 1'b0;
		else
			por_start_q <= POR_I;
	end

	nvc_prog_timer #(.LEN(PWRT_CYCLES)) u_pwrt
	(
		.clk_i   (CLK_SYS_I),
		.rst_b_i (RST_B_I),
		.start_i (POR_I && !por_start_q),
		.abort_i (1'b0),
		.busy_o  (pwrt_busy),
		.done_o  ()
	);

	nvc_prog_timer #(.LEN(PROG_CYCLES)) u_prog
	(
		.clk_i   (CLK_SYS_I),
		.rst_b_i (RST_B_I),
		.start_i (launch),
		.abort_i (1'b0),
		.busy_o  (prog_busy),
		.done_o  (prog_done)
	);

	////////////////////////////////////////////////////////////////////
	// control path
	logic commit_req;
	logic key_ok;
	assign commit_req = hit(wr_acc, PADDR_I, NVC_OFF_CTRL) && wbyte[NVC_BIT_COMMIT];
	assign key_ok = (key_q == NVC_KEY_OPEN);
	// commit accepted only with permit, keys, no power-up hold, no write running, and both pgmsel and cfgsel clear
	assign launch = commit_req && !write_busy && key_ok && ctrl_q[NVC_BIT_PERMIT]
		&& !pwrt_busy && !ctrl_q[NVC_BIT_PGMSEL] && !ctrl_q[NVC_BIT_CFGSEL];

	always_comb
	begin
		adr_lo_d = adr_lo_q;
		adr_hi_d = adr_hi_q;
		data_d   = data_q;
		ctrl_d   = ctrl_q;
		flags4_d = flags4_q;
		en4_d    = en4_q;
		prio4_d  = prio4_q;
		key_d    = key_q;
		wadr_d   = wadr_q;
		wdat_d   = wdat_q;
		if (!write_busy)
		begin
			if (hit(wr_acc, PADDR_I, NVC_OFF_ADDR_LOW))
				adr_lo_d = wbyte;
			if (hit(wr_acc, PADDR_I, NVC_OFF_ADDR_HIGH))
				adr_hi_d = wbyte;
			if (hit(wr_acc, PADDR_I, NVC_OFF_DATA))
				data_d = wbyte;
			if (hit(wr_acc, PADDR_I, NVC_OFF_CTRL))
			begin
				// permit only changed here; permit taken from old value
				ctrl_d = (ctrl_q & ~NVC_CTRL_WMASK) | (wbyte & NVC_CTRL_WMASK);
				if (wbyte[NVC_BIT_READ] && !wbyte[NVC_BIT_PGMSEL])
					data_d = mem[cur_adr];
			end
		end
		// key sequence tracker; any other write breaks it, reads do not
		if (hit(wr_acc, PADDR_I, NVC_OFF_KEY))
		begin
			if (wbyte == NVC_KEY_FIRST)
				key_d = NVC_KEY_HALF;
			else if (wbyte == NVC_KEY_SECOND && key_q == NVC_KEY_HALF)
				key_d = NVC_KEY_OPEN;
			else
				key_d = NVC_KEY_IDLE;
		end
		else if (wr_acc)
			key_d = NVC_KEY_IDLE;
		if (launch)
		begin
			ctrl_d[NVC_BIT_COMMIT] = 1'b1;
			ctrl_d[NVC_BIT_ABORT]  = 1'b0;
			wadr_d = cur_adr;
			wdat_d = data_q;
		end
		else if (commit_req && !write_busy)
		begin
			ctrl_d[NVC_BIT_ABORT] = 1'b1;
		end
		// read launch never stays set
		ctrl_d[NVC_BIT_READ] = 1'b0;
		if (hit(wr_acc, PADDR_I, NVC_OFF_FLAGS4))
			flags4_d = wbyte & NVC_G4_MASK;
		if (hit(wr_acc, PADDR_I, NVC_OFF_ENABLES4))
			en4_d = wbyte & NVC_G4_MASK;
		if (hit(wr_acc, PADDR_I, NVC_OFF_PRIO4))
			prio4_d = wbyte & NVC_G4_MASK;
		if (prog_done)
		begin
			ctrl_d[NVC_BIT_COMMIT]  = 1'b0;
			flags4_d[NVC_BIT_DONE] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			adr_lo_q   <= NVC_ZERO_BYTE;
			adr_hi_q   <= NVC_ZERO_BYTE;
			data_q     <= NVC_ZERO_BYTE;
			ctrl_q     <= NVC_ZERO_BYTE;
			flags4_q   <= NVC_ZERO_BYTE;
			en4_q      <= NVC_ZERO_BYTE;
			prio4_q    <= NVC_ZERO_BYTE;
			key_q      <= NVC_KEY_IDLE;
			wadr_q     <= '0;
			wdat_q     <= NVC_ZERO_BYTE;
			rst_seen_q <= 1'b0;
		end
		else
		begin
			adr_lo_q   <= adr_lo_d;
			adr_hi_q   <= adr_hi_d;
			data_q     <= data_d;
			ctrl_q     <= ctrl_d;
			flags4_q   <= flags4_d;
			en4_q      <= en4_d;
			prio4_q    <= prio4_d;
			key_q      <= key_d;
			wadr_q     <= wadr_d;
			wdat_q     <= wdat_d;
			rst_seen_q <= 1'b1;
		end
	end

	// erase-before-write: the byte is replaced whole at completion
	always_ff @(posedge CLK_SYS_I)
	begin
		if (prog_done)
			mem[wadr_q] <= wdat_q;
		else if (ext_den_d == 1'b0 && EXT_REQ_I && EXT_WRITE_I && !write_busy)
			mem[EXT_ADDR_I] <= EXT_WDATA_I;
	end

	////////////////////////////////////////////////////////////////////
	// external programming port
	always_comb
	begin
		ext_d     = ext_q;
		ext_den_d = 1'b0;
		if (EXT_REQ_I)
		begin
			// code protect blocks only this port
			ext_den_d = CODE_PROTECT_I;
			if (!CODE_PROTECT_I && !EXT_WRITE_I)
				ext_d = mem[EXT_ADDR_I];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			ext_q     <= NVC_ZERO_BYTE;
			ext_den_q <= 1'b0;
		end
		else
		begin
			ext_q     <= ext_d;
			ext_den_q <= ext_den_d;
		end
	end

	assign EXT_RDATA_O  = ext_q;
	assign EXT_DENIED_O = ext_den_q;

	// high power while a self-write runs with the low-power oscillator selected
	assign HIGH_POWER_REQ_O = prog_busy && LOW_POWER_OSC_I;
	assign DONE_IRQ_O = flags4_q[NVC_BIT_DONE] && en4_q[NVC_BIT_DONE];

	////////////////////////////////////////////////////////////////////
	// read mux
	always_comb
	begin
		PRDATA_O = '0;
		if (rd_acc)
		begin
			case (PADDR_I)
				NVC_OFF_ADDR_LOW:  PRDATA_O[7:0] = adr_lo_q;
				NVC_OFF_ADDR_HIGH: PRDATA_O[7:0] = adr_hi_q;
				NVC_OFF_DATA:      PRDATA_O[7:0] = data_q;
				NVC_OFF_KEY:       PRDATA_O[7:0] = NVC_ZERO_BYTE;
				NVC_OFF_CTRL:      PRDATA_O[7:0] = ctrl_q;
				NVC_OFF_FLAGS4:    PRDATA_O[7:0] = flags4_q;
				NVC_OFF_ENABLES4:  PRDATA_O[7:0] = en4_q;
				NVC_OFF_PRIO4:     PRDATA_O[7:0] = prio4_q;
				default:           PRDATA_O[7:0] = NVC_ZERO_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	// commit clears on done
	property p_commit_clear;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		prog_done |=> !ctrl_q[NVC_BIT_COMMIT] && flags4_q[NVC_BIT_DONE];
	endproperty
	a_commit_clear: assert property (p_commit_clear) else $error("commit not cleared");

	property p_no_permit;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		commit_req && !ctrl_q[NVC_BIT_PERMIT] && !write_busy |=> !ctrl_q[NVC_BIT_COMMIT];
	endproperty
	a_no_permit: assert property (p_no_permit) else $error("commit without permit");

	property p_keys;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		$rose(ctrl_q[NVC_BIT_COMMIT]) |-> $past(key_q) == NVC_KEY_OPEN;
	endproperty
	a_keys: assert property (p_keys) else $error("launch without keys");

	property p_frozen;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		write_busy && ctrl_d[NVC_BIT_COMMIT] |=> $stable(adr_lo_q) && $stable(data_q);
	endproperty
	a_frozen: assert property (p_frozen) else $error("registers changed in write");

	property p_permit_kept;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		prog_done && ctrl_q[NVC_BIT_PERMIT] |=> ctrl_q[NVC_BIT_PERMIT];
	endproperty
	a_permit_kept: assert property (p_permit_kept) else $error("permit dropped");

	property p_pwrt;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		pwrt_busy |-> !launch;
	endproperty
	a_pwrt: assert property (p_pwrt) else $error("write in power-up period");

	property p_read_clear;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		rst_seen_q |-> !ctrl_q[NVC_BIT_READ];
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read bit stuck");

	property p_key_zero;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		hit(rd_acc, PADDR_I, NVC_OFF_KEY) |-> PRDATA_O == '0;
	endproperty
	a_key_zero: assert property (p_key_zero) else $error("key port not zero");

	c_launch: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) launch);
	c_done: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) prog_done);
	c_abort: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		$rose(ctrl_q[NVC_BIT_ABORT]));
endmodule

// ==== testbench/test_data_nv_byte_access_ctrl.sv ====
`timescale 1ns/1ps
module test_data_nv_byte_access_ctrl;
	import nvc_pkg::*;
	// short timers keep the run small
	localparam int PROG_LEN = 20;
	localparam int PWRT_LEN = 30;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        por = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        code_protect = 1'b0;
	logic        ext_req = 1'b0;
	logic        ext_write = 1'b0;
	logic [9:0]  ext_addr = 10'h000;
	logic [7:0]  ext_wdata = 8'h00;
	logic        low_power_osc = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  ext_rdata;
	logic        ext_denied;
	logic        high_power_req;
	logic        done_irq;
	logic [7:0]  rd_byte;
	logic        rd_err;
	int          n_fail = 0;
	int          check_count = 0;

	always #12.5 clk_sys = ~clk_sys;

	nvc_top #(.PROG_CYCLES(PROG_LEN), .PWRT_CYCLES(PWRT_LEN)) dut
	(
		.CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .POR_I(por),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr),
		.CODE_PROTECT_I(code_protect), .EXT_REQ_I(ext_req),
		.EXT_WRITE_I(ext_write), .EXT_ADDR_I(ext_addr),
		.EXT_WDATA_I(ext_wdata), .EXT_RDATA_O(ext_rdata),
		.EXT_DENIED_O(ext_denied), .LOW_POWER_OSC_I(low_power_osc),
		.HIGH_POWER_REQ_O(high_power_req), .DONE_IRQ_O(done_irq)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one idle cycle before each setup, so no signal is driven twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		logic rdy;
		int   n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		// answer taken at the rising edge where pready is seen high
		do
		begin
			@(posedge clk_sys);
			rdy = pready;
			rd_byte = prdata[7:0];
			rd_err = pslverr;
			n++;
		end
		while (rdy !== 1'b1 && n < 20);
		if (n >= 20)
			check(8'h00, 8'h01, "no ready");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask

	task automatic keys();
		wr(NVC_OFF_KEY, NVC_KEY_FIRST);
		wr(NVC_OFF_KEY, NVC_KEY_SECOND);
	endtask

	task automatic ext_op(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		ext_req <= 1'b1;
		ext_write <= w;
		ext_addr <= a;
		ext_wdata <= d;
		@(posedge clk_sys);
		ext_req <= 1'b0;
		@(negedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(NVC_OFF_CTRL);
		check(rd_byte, 8'h00, "ctrl after reset");
		rd(NVC_OFF_KEY);
		check(rd_byte, 8'h00, "key port read");
		rd(8'h20);
		check({7'h0, rd_err}, 8'h01, "unmapped error");
		$display("test reset done");
	endtask

	task automatic t_power_up();
		por <= 1'b1;
		wr(NVC_OFF_DATA, 8'h11);
		wr(NVC_OFF_CTRL, 8'h04);
		keys();
		wr(NVC_OFF_CTRL, 8'h06);
		rd(NVC_OFF_CTRL);
		check(rd_byte, 8'h0c, "commit in power-up time");
		repeat (PWRT_LEN) @(posedge clk_sys);
		$display("test power_up done");
	endtask

	task automatic t_write();
		int n;
		low_power_osc <= 1'b1;
		wr(NVC_OFF_ADDR_LOW, 8'h5a);
		wr(NVC_OFF_ADDR_HIGH, 8'hfd);
		wr(NVC_OFF_DATA, 8'h3c);
		keys();
		// permit set earlier, no interrupts here
		wr(NVC_OFF_CTRL, 8'h06);
		@(negedge clk_sys);
		check({7'h0, high_power_req}, 8'h01, "high power");
		// frozen while busy: none of these may land
		wr(NVC_OFF_DATA, 8'h99);
		wr(NVC_OFF_ADDR_LOW, 8'h00);
		wr(NVC_OFF_CTRL, 8'h00);
		rd(NVC_OFF_CTRL);
		check(rd_byte, 8'h06, "busy ctrl");
		n = 0;
		do
		begin
			rd(NVC_OFF_CTRL);
			n++;
		end
		while (rd_byte[NVC_BIT_COMMIT] !== 1'b0 && n < 40);
		check(rd_byte, 8'h04, "ctrl after write");
		check({7'h0, high_power_req}, 8'h00, "high power released");
		rd(NVC_OFF_DATA);
		check(rd_byte, 8'h3c, "data kept");
		rd(NVC_OFF_ADDR_LOW);
		check(rd_byte, 8'h5a, "address kept");
		rd(NVC_OFF_FLAGS4);
		check(rd_byte & 8'h40, 8'h40, "done flag");
		wr(NVC_OFF_ENABLES4, 8'h40);
		@(negedge clk_sys);
		check({7'h0, done_irq}, 8'h01, "done irq");
		wr(NVC_OFF_FLAGS4, 8'h00);
		rd(NVC_OFF_FLAGS4);
		check(rd_byte & 8'h40, 8'h00, "flag cleared");
		low_power_osc <= 1'b0;
		// upper six bits of the high byte must not matter
		wr(NVC_OFF_ADDR_HIGH, 8'h01);
		wr(NVC_OFF_DATA, 8'h00);
		rd(NVC_OFF_DATA);
		check(rd_byte, 8'h00, "data overwritten");
		wr(NVC_OFF_CTRL, 8'h01);
		rd(NVC_OFF_DATA);
		check(rd_byte, 8'h3c, "read back");
		rd(NVC_OFF_CTRL);
		check(rd_byte, 8'h00, "read bit clears");
		$display("test write done");
	endtask

	task automatic attempt(input logic [7:0] pre, input logic brk, input logic [7:0] exp);
		wr(NVC_OFF_CTRL, pre);
		wr(NVC_OFF_KEY, NVC_KEY_FIRST);
		if (brk)
			wr(NVC_OFF_DATA, 8'h77);
		wr(NVC_OFF_KEY, NVC_KEY_SECOND);
		wr(NVC_OFF_CTRL, pre | 8'h02);
		rd(NVC_OFF_CTRL);
		check(rd_byte, exp, "refused commit");
	endtask

	task automatic t_refusals();
		attempt(8'h00, 1'b0, 8'h08);
		attempt(8'h04, 1'b1, 8'h0c);
		attempt(8'h84, 1'b0, 8'h8c);
		wr(NVC_OFF_CTRL, 8'h01);
		rd(NVC_OFF_DATA);
		check(rd_byte, 8'h3c, "array untouched");
		$display("test refusals done");
	endtask

	task automatic t_external();
		code_protect <= 1'b1;
		ext_op(1'b0, 10'h15a, 8'h00);
		check({7'h0, ext_denied}, 8'h01, "ext read denied");
		ext_op(1'b1, 10'h15a, 8'he1);
		check({7'h0, ext_denied}, 8'h01, "ext write denied");
		wr(NVC_OFF_CTRL, 8'h01);
		rd(NVC_OFF_DATA);
		check(rd_byte, 8'h3c, "internal read protected");
		code_protect <= 1'b0;
		ext_op(1'b0, 10'h15a, 8'h00);
		check({7'h0, ext_denied}, 8'h00, "ext read allowed");
		check(ext_rdata, 8'h3c, "ext read data");
		$display("test external done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_power_up();
		t_write();
		t_refusals();
		t_external();
		give_verdict();
	end

	// whole run is well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
